// File: common/flash_host_pkg.sv
// Shared constants, types and state codes for the parallel flash host controller
package flash_host_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and bus timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned T_ACC_NS      = 70;
    localparam int unsigned T_WP_NS       = 35;
    localparam int unsigned T_REC_NS      = 20;
    // Least times round up to whole cycles
    localparam logic [3:0] ACC_CYC =
        4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WP_CYC =
        4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] REC_CYC =
        4'((T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    // Software register map
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_ADDR   = 3'h1;
    localparam logic [2:0] REG_WDATA  = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RDATA  = 3'h4;
    localparam int unsigned CTRL_START_POS = 3;
    localparam int unsigned CTRL_WORD_POS  = 4;
    localparam int unsigned STAT_DONE_POS  = 1;
    localparam int unsigned STAT_FAIL_POS  = 2;
    localparam int unsigned STAT_REJ_POS   = 4;
    localparam logic        WORD_MODE_RST  = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Status bit positions and command codes
    localparam int unsigned TOGGLE_BIT_ONE_POS = 6;
    localparam int unsigned TOGGLE_BIT_TWO_POS = 2;
    localparam int unsigned TIMING_EXCEEDED_POS = 5;
    localparam logic [7:0]  CMD_UNLOCK_A = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK_B = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_RESET    = 8'hf0;
    localparam logic [19:0] UNLOCK1_W = 20'h00555;
    localparam logic [19:0] UNLOCK2_W = 20'h002aa;
    localparam logic [19:0] UNLOCK1_B = 20'h00aaa;
    localparam logic [19:0] UNLOCK2_B = 20'h00555;
    localparam logic [2:0]  PROG_LEN  = 3'h4;
    localparam logic [2:0]  ERASE_LEN = 3'h6;
    localparam logic [15:0] OE_N_WORD_WR = 16'h0000;
    localparam logic [15:0] OE_N_BYTE_WR = 16'h7f00;
    localparam logic [15:0] OE_N_BYTE_RD = 16'h7fff;
    localparam logic [15:0] OE_N_RELEASE = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_PROG  = 3'h2,
        OP_ERASE = 3'h3,
        OP_RESET = 3'h4
    } op_t;

    typedef enum logic [5:0] {
        S_IDLE       = 6'b000001,
        S_CMD_WAIT   = 6'b000010,
        S_POLL_WAIT  = 6'b000100,
        S_EVAL       = 6'b001000,
        S_FINAL_WAIT = 6'b010000,
        S_FAIL_WAIT  = 6'b100000
    } ctl_state_t;

    typedef enum logic [3:0] {
        B_IDLE    = 4'b0001,
        B_SETUP   = 4'b0010,
        B_STROBE  = 4'b0100,
        B_RECOVER = 4'b1000
    } bus_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [18:0] addr;
    } flash_pins_t;

    typedef struct packed {
        logic        write;
        logic [19:0] addr;
        logic [15:0] data;
    } cyc_req_t;

    localparam flash_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000};

endpackage

// File: logic/flash_bus_cycle.sv
// One timed read or write cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        word_mode_i,
    input  wire cyc_req_t    req_i,
    input  wire logic [15:0] dq_i,
    output flash_pins_t      pins_o,
    output logic [15:0]      dq_o,
    output logic [15:0]      dq_oe_n_o,
    output logic [15:0]      rdata_o,
    output logic             done_o
);

    bus_state_t state;
    logic       cur_write;
    logic [3:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state     <= B_IDLE;
            pins_o    <= PINS_IDLE;
            dq_o      <= 16'h0000;
            dq_oe_n_o <= OE_N_RELEASE;
            rdata_o   <= 16'h0000;
            done_o    <= 1'b0;
            cur_write <= 1'b0;
            cnt       <= 4'h0;
        end else begin
            done_o <= 1'b0;
            case (state)
                B_IDLE: begin
                    if (start_i) begin
                        cur_write   <= req_i.write;
                        pins_o.ce_n <= 1'b0;
                        // Byte mode: top data line carries the lowest address bit
                        if (word_mode_i) begin
                            pins_o.addr <= req_i.addr[18:0];
                            dq_o        <= req_i.data;
                            dq_oe_n_o   <= req_i.write ? OE_N_WORD_WR : OE_N_RELEASE;
                        end else begin
                            pins_o.addr <= req_i.addr[19:1];
                            dq_o        <= {req_i.addr[0], 7'h00, req_i.data[7:0]};
                            dq_oe_n_o   <= req_i.write ? OE_N_BYTE_WR : OE_N_BYTE_RD;
                        end
                        state <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    // Write strobe only with chip select low and output enable high
                    if (cur_write) begin
                        pins_o.we_n <= 1'b0;
                        cnt         <= WP_CYC - 4'h1;
                    end else begin
                        pins_o.oe_n <= 1'b0;
                        cnt         <= ACC_CYC - 4'h1;
                    end
                    state <= B_STROBE;
                end
                B_STROBE: begin
                    if (cnt == 4'h0) begin
                        // All strobes rise together, so every access is a distinct cycle
                        pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                    addr: pins_o.addr};
                        if (!cur_write) begin
                            rdata_o <= dq_i;
                        end
                        cnt   <= REC_CYC - 4'h1;
                        state <= B_RECOVER;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                B_RECOVER: begin
                    dq_oe_n_o <= OE_N_RELEASE;
                    if (cnt == 4'h0) begin
                        done_o <= 1'b1;
                        state  <= B_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: state <= B_IDLE;
            endcase
        end
    end

endmodule // flash_bus_cycle

// File: logic/toggle_check.sv
// Compares one status bit across two successive reads
`timescale 1ns/1ps
module toggle_check
    import flash_host_pkg::*;
#(
    parameter int unsigned BIT_POS = 6
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sample_i,
    input  wire logic       first_i,
    input  wire logic [7:0] data_i,
    output logic            toggled_o,
    output logic            timeout_o
);

    logic prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev      <= 1'b0;
            toggled_o <= 1'b0;
            timeout_o <= 1'b0;
        end else if (sample_i) begin
            prev <= data_i[BIT_POS];
            // Verdict only after the second of a pair
            if (!first_i) begin
                toggled_o <= prev ^ data_i[BIT_POS];
                timeout_o <= data_i[TIMING_EXCEEDED_POS];
            end
        end
    end

endmodule // toggle_check

// File: logic/flash_host_ctl.sv
// Host controller: command sequences, toggle-bit polling and status for a parallel flash
//
// Overview of operation
// - Start status check with two compared reads
// - Equal toggle bit: done, next read array
// - Toggling: check timing flag, recheck if set
// - Still toggling after flag: fail, send reset
// - Flag low: keep polling, restart from two reads
// - Write needs select, strobe low, enable high
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module flash_host_ctl
    import flash_host_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output flash_pins_t      pins_o,
    input  wire logic [15:0] dq_i,
    output logic [15:0]      dq_o,
    output logic [15:0]      dq_oe_n_o,
    output logic             word_mode_o,
    output logic             flash_rst_n_o,
    input  wire logic        busy_ready_out_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ctl_state_t  state;
    op_t         op;
    logic [19:0] op_addr;
    logic [15:0] op_wdata;
    logic [15:0] rdata_cap;
    logic [2:0]  step;
    logic        poll_first;
    logic        recheck;
    logic        done;
    logic        fail;
    logic        rejected;
    logic        finish_ok;
    logic        finish_fail;
    logic        cyc_start;
    cyc_req_t    cyc_req;
    logic [15:0] cyc_rdata;
    logic        cyc_done;
    logic        tb1_tog;
    logic        tb2_tog;
    logic        tb_timeout;
    logic        sample;
    logic        start_wr;
    logic        start_ok;
    op_t         start_op;
    logic [2:0]  seq_len;

    ////////////////////////////////////////////////////////////////////////////
    // Command sequence table
    function automatic cyc_req_t seq_entry(input op_t o, input logic [2:0] s,
                                           input logic w, input logic [19:0] a,
                                           input logic [15:0] d);
        cyc_req_t    r;
        logic [19:0] u1;
        logic [19:0] u2;
        u1 = w ? UNLOCK1_W : UNLOCK1_B;
        u2 = w ? UNLOCK2_W : UNLOCK2_B;
        r  = '{write: 1'b1, addr: a, data: {8'h00, CMD_RESET}};
        // Command bytes always ride the low data lines only
        case (o)
            OP_READ:  r.write = 1'b0;
            OP_WRITE: r.data = {8'h00, d[7:0]};
            OP_PROG: begin
                case (s)
                    3'h0:    r = '{1'b1, u1, {8'h00, CMD_UNLOCK_A}};
                    3'h1:    r = '{1'b1, u2, {8'h00, CMD_UNLOCK_B}};
                    3'h2:    r = '{1'b1, u1, {8'h00, CMD_PROGRAM}};
                    default: r = '{1'b1, a, d};
                endcase
            end
            OP_ERASE: begin
                case (s)
                    3'h0:    r = '{1'b1, u1, {8'h00, CMD_UNLOCK_A}};
                    3'h1:    r = '{1'b1, u2, {8'h00, CMD_UNLOCK_B}};
                    3'h2:    r = '{1'b1, u1, {8'h00, CMD_ERASE}};
                    3'h3:    r = '{1'b1, u1, {8'h00, CMD_UNLOCK_A}};
                    3'h4:    r = '{1'b1, u2, {8'h00, CMD_UNLOCK_B}};
                    default: r = '{1'b1, a, {8'h00, CMD_SECTOR}};
                endcase
            end
            default: r.data = {8'h00, CMD_RESET};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Start decode
    assign start_op = op_t'(wdata_i[2:0]);
    assign start_wr = wr_i && (addr_i == REG_CTRL) && wdata_i[CTRL_START_POS];
    // Program or erase is refused while the device reports busy
    assign start_ok = (state == S_IDLE) &&
                      (busy_ready_out_i ||
                       !((start_op == OP_PROG) || (start_op == OP_ERASE)));
    // The full sequence is always sent, so the array is only touched by a whole one
    assign seq_len  = (op == OP_PROG) ? PROG_LEN :
                      (op == OP_ERASE) ? ERASE_LEN : 3'h1;
    assign sample   = cyc_done && (state == S_POLL_WAIT);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state       <= S_IDLE;
            op          <= OP_READ;
            step        <= 3'h0;
            poll_first  <= 1'b1;
            recheck     <= 1'b0;
            cyc_start   <= 1'b0;
            cyc_req     <= '0;
            rdata_cap   <= 16'h0000;
            finish_ok   <= 1'b0;
            finish_fail <= 1'b0;
        end else begin
            cyc_start   <= 1'b0;
            finish_ok   <= 1'b0;
            finish_fail <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_wr && start_ok) begin
                        op        <= start_op;
                        step      <= 3'h0;
                        cyc_req   <= seq_entry(start_op, 3'h0, word_mode_o, op_addr, op_wdata);
                        cyc_start <= 1'b1;
                        state     <= S_CMD_WAIT;
                    end
                end
                S_CMD_WAIT: begin
                    if (cyc_done) begin
                        if (op == OP_READ) begin
                            rdata_cap <= cyc_rdata;
                            finish_ok <= 1'b1;
                            state     <= S_IDLE;
                        end else if (step == seq_len - 3'h1) begin
                            // Status is valid only after the last write pulse
                            if ((op == OP_PROG) || (op == OP_ERASE)) begin
                                cyc_req    <= '{write: 1'b0, addr: op_addr, data: 16'h0000};
                                cyc_start  <= 1'b1;
                                poll_first <= 1'b1;
                                recheck    <= 1'b0;
                                state      <= S_POLL_WAIT;
                            end else begin
                                finish_ok <= 1'b1;
                                state     <= S_IDLE;
                            end
                        end else begin
                            step      <= step + 3'h1;
                            cyc_req   <= seq_entry(op, step + 3'h1, word_mode_o,
                                                   op_addr, op_wdata);
                            cyc_start <= 1'b1;
                        end
                    end
                end
                S_POLL_WAIT: begin
                    if (cyc_done) begin
                        if (poll_first) begin
                            // Second read of the pair; strobes have been high between
                            poll_first <= 1'b0;
                            cyc_start  <= 1'b1;
                        end else begin
                            state <= S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    poll_first <= 1'b1;
                    cyc_start  <= 1'b1;
                    if (!tb1_tog) begin
                        state <= S_FINAL_WAIT;
                    end else if (recheck) begin
                        cyc_req <= seq_entry(OP_RESET, 3'h0, word_mode_o, op_addr, op_wdata);
                        state   <= S_FAIL_WAIT;
                    end else if (tb_timeout) begin
                        recheck <= 1'b1;
                        state   <= S_POLL_WAIT;
                    end else begin
                        // Keep polling; each round starts again with a fresh pair
                        state <= S_POLL_WAIT;
                    end
                end
                S_FINAL_WAIT: begin
                    if (cyc_done) begin
                        rdata_cap <= cyc_rdata;
                        finish_ok <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_FAIL_WAIT: begin
                    if (cyc_done) begin
                        finish_fail <= 1'b1;
                        state       <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_mode_o   <= WORD_MODE_RST;
            flash_rst_n_o <= 1'b1;
            op_addr       <= 20'h00000;
            op_wdata      <= 16'h0000;
        end else if (wr_i && (state == S_IDLE)) begin
            // Width only changes between operations, never mid-sequence
            if (addr_i == REG_CTRL) begin
                word_mode_o <= wdata_i[CTRL_WORD_POS];
            end
            if (addr_i == REG_ADDR) begin
                op_addr <= wdata_i[19:0];
            end
            if (addr_i == REG_WDATA) begin
                op_wdata <= wdata_i[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done     <= 1'b0;
            fail     <= 1'b0;
            rejected <= 1'b0;
        end else begin
            done <= finish_ok || finish_fail ||
                    (done && !(wr_i && (addr_i == REG_STATUS) && wdata_i[STAT_DONE_POS]));
            fail <= finish_fail ||
                    (fail && !(wr_i && (addr_i == REG_STATUS) && wdata_i[STAT_FAIL_POS]));
            rejected <= (start_wr && !start_ok) ||
                        (rejected && !(wr_i && (addr_i == REG_STATUS) &&
                                       wdata_i[STAT_REJ_POS]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else if (rd_i) begin
            case (addr_i)
                REG_CTRL:   rdata_o <= {27'h0, word_mode_o, 1'b0, op};
                REG_ADDR:   rdata_o <= {12'h000, op_addr};
                REG_WDATA:  rdata_o <= {16'h0000, op_wdata};
                REG_STATUS: rdata_o <= {25'h0, tb_timeout, tb2_tog, rejected,
                                        busy_ready_out_i, fail, done, state != S_IDLE};
                REG_RDATA:  rdata_o <= {16'h0000, rdata_cap};
                default:    rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin engine and toggle comparators
    flash_bus_cycle u_bus (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .start_i     (cyc_start),
        .word_mode_i (word_mode_o),
        .req_i       (cyc_req),
        .dq_i        (dq_i),
        .pins_o      (pins_o),
        .dq_o        (dq_o),
        .dq_oe_n_o   (dq_oe_n_o),
        .rdata_o     (cyc_rdata),
        .done_o      (cyc_done)
    );

    toggle_check #(.BIT_POS(TOGGLE_BIT_ONE_POS)) u_tb1 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .sample_i  (sample),
        .first_i   (poll_first),
        .data_i    (cyc_rdata[7:0]),
        .toggled_o (tb1_tog),
        .timeout_o (tb_timeout)
    );

    // Second toggle bit tells erasing from suspended sector
    toggle_check #(.BIT_POS(TOGGLE_BIT_TWO_POS)) u_tb2 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .sample_i  (sample),
        .first_i   (poll_first),
        .data_i    (cyc_rdata[7:0]),
        .toggled_o (tb2_tog),
        .timeout_o ()
    );

endmodule // flash_host_ctl

// File: verif/flash_host_ctl_assertions.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/1ps
module flash_host_ctl_assertions
    import flash_host_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire flash_pins_t pins_o,
    input wire logic [15:0] dq_oe_n_o,
    input wire logic        word_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    property p_wr_ok; !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n; endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write strobe while inhibited");
    property p_we_len; $fell(pins_o.we_n) |=> !pins_o.we_n ##1 pins_o.we_n; endproperty
    a_we_len: assert property (p_we_len) else $error("write pulse length");
    property p_gap; $rose(pins_o.oe_n) |=> pins_o.oe_n && pins_o.ce_n; endproperty
    a_gap: assert property (p_gap) else $error("no idle between reads");
    property p_addr; !pins_o.ce_n |=> $stable(pins_o.addr) || pins_o.ce_n; endproperty
    a_addr: assert property (p_addr) else $error("address moved in access");
    property p_rd_len; $fell(pins_o.oe_n) |-> !pins_o.oe_n[*3] ##1 pins_o.oe_n; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");
    property p_no_fight; !pins_o.oe_n |-> &dq_oe_n_o[14:0]; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven during read");
    property p_lanes;
        !pins_o.we_n |-> dq_oe_n_o == (word_mode_o ? OE_N_WORD_WR : OE_N_BYTE_WR);
    endproperty
    a_lanes: assert property (p_lanes) else $error("wrong write lanes");
    property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    c_write: cover property ($fell(pins_o.we_n));
    c_read: cover property ($fell(pins_o.oe_n));
    c_byte: cover property (!pins_o.we_n && !word_mode_o);
endmodule // flash_host_ctl_assertions
bind flash_host_ctl flash_host_ctl_assertions u_flash_host_ctl_assertions (.clk_i(clk_i),
    .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_o(pins_o),
    .dq_oe_n_o(dq_oe_n_o), .word_mode_o(word_mode_o));

// File: verif/flash_dev_model.sv
// Behavioural parallel flash device driven from its pins
`timescale 1ns/1ps
module flash_dev_model
    import flash_host_pkg::*;
(
    input  wire flash_pins_t pins_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        stuck_i,
    input  wire logic [7:0]  busy_reads_i,
    output logic [15:0]      dq_o,
    output logic             busy_ready_out_o
);
    logic [15:0] arr = 16'hffff;
    logic [15:0] val;
    logic [7:0]  left = 8'h00;
    logic [2:0]  nw = 3'h0;
    logic        erase = 1'b0, t1 = 1'b0, t2 = 1'b0, fail = 1'b0, ok = 1'b0;
    initial busy_ready_out_o = 1'b1;
    ////////////////////////////////////////////////////////////
    // Qualify at the falling strobe: the pins struct changes as a whole
    always @(negedge pins_i.we_n) ok = !pins_i.ce_n && pins_i.oe_n;
    always @(posedge pins_i.we_n) begin
        if (ok && dq_i[7:0] == CMD_RESET) begin
            nw = 3'h0;
            fail = 1'b0;
            busy_ready_out_o = 1'b1;
        end else if (ok && busy_ready_out_o) begin
            nw = nw + 3'h1;
            if (nw == 3'h3)
                erase = (dq_i[7:0] == CMD_ERASE);
            if (nw == (erase ? ERASE_LEN : PROG_LEN)) begin
                nw = 3'h0;
                // Top sector is protected: a full sequence aimed there starts nothing
                if (pins_i.addr[18:16] != 3'h7) begin
                    arr = erase ? 16'hffff : dq_i;
                    left = busy_reads_i;
                    busy_ready_out_o = 1'b0;
                end
            end
        end
    end
    // Each new read access advances toggle bit one while busy, and toggle bit two only while erasing
    always @(negedge pins_i.oe_n or negedge pins_i.ce_n) begin
        if (!pins_i.ce_n && !pins_i.oe_n && !busy_ready_out_o) begin
            t1 = ~t1;
            t2 = erase ? ~t2 : t2;
            if (left != 8'h00)
                left = left - 8'h01;
            else if (stuck_i)
                fail = 1'b1;
            else
                busy_ready_out_o = 1'b1;
        end
    end
    assign val = busy_ready_out_o ? arr
        : {8'h00, erase ? 1'b0 : ~arr[7], t1, fail, 2'b00, erase ? t2 : 1'b1, 2'b00};
    // Released bus shows the inverse so a stale value never passes
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? val : ~val;
endmodule // flash_dev_model

// File: verif/flash_host_ctl_tb_top.sv
// Testbench for the flash host controller
`timescale 1ns/1ps
module flash_host_ctl_tb_top
    import flash_host_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [2:0]  addr_i = 3'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o, v;
    flash_pins_t pins_o;
    logic [15:0] dq_i, dq_o, dq_oe_n_o;
    logic        word_mode_o, flash_rst_n_o, ready, stuck = 1'b0;
    logic [7:0]  slow = 8'h03;
    int          n_mismatch = 0, num_checks = 0, cyc = 0;
    flash_host_ctl u_flash_host_ctl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_o(pins_o),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .word_mode_o(word_mode_o),
        .flash_rst_n_o(flash_rst_n_o), .busy_ready_out_i(ready));
    flash_dev_model u_flash_dev_model (.pins_i(pins_o), .dq_i(dq_o), .stuck_i(stuck),
        .busy_reads_i(slow), .dq_o(dq_i), .busy_ready_out_o(ready));
    ////////////////////////////////////////////////////////////
    initial forever #12.5 clk_i = ~clk_i;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A gap cycle after each write keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [2:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic run(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(REG_ADDR, a);
        wr(REG_WDATA, d);
        wr(REG_CTRL, c);
        if (c[2:0] == 3'h3) wr(REG_CTRL, 32'h1a);
        for (int i = 0; i < 600; i++) begin
            rd(REG_STATUS);
            if (v[0] === 1'b0) break;
        end
        rd(REG_STATUS);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        chk({10'h0, pins_o}, {10'h0, PINS_IDLE});
        chk({16'h0, dq_oe_n_o}, 32'hffff);
        chk({31'h0, flash_rst_n_o}, 32'h1);
        rst_i <= 1'b0;
        rd(REG_STATUS);
        chk(v, 32'h8);
        run(32'h100, 32'h1234, 32'h1a);
        // Last poll pair reads array byte 0x34, so the timing flag shows bit 5 set
        chk(v, 32'h4a);
        rd(REG_RDATA);
        chk(v, 32'h1234);
        wr(REG_STATUS, 32'h16);
        slow <= 8'd40;
        run(32'h8000, 32'h0, 32'h1b);
        chk(v & 32'h1f, 32'h1a);
        rd(REG_RDATA);
        chk(v, 32'hffff);
        wr(REG_STATUS, 32'h16);
        stuck <= 1'b1;
        slow <= 8'h02;
        run(32'h200, 32'h5678, 32'h1a);
        chk(v & 32'h5f, 32'h4e);
        run(32'h7f000, 32'h0, 32'h1a);
        rd(REG_RDATA);
        chk(v, 32'h5678);
        wr(REG_STATUS, 32'h16);
        stuck <= 1'b0;
        run(32'h0, 32'h12f0, 32'h09);
        chk(v & 32'hb, 32'ha);
        chk({31'h0, word_mode_o}, 32'h0);
        give_verdict();
    end
endmodule // flash_host_ctl_tb_top
